/* hw/spi_readback_echo_decoder.sv */
/*
 Serial command decoder for read-back, simple diagnosis and echo test.
 Assumes an SPI master in mode 1 style: data driven on rising clock and
 sampled on falling clock, MSB first, 16-bit frames under chip select.
 Serial clock is sampled by clk_i, so it must be well below 25 MHz.
*/
`timescale 1ns/10ps
`include "readback_defines.svh"

// Functional notes
// RQ1 - C0 control: read-back channels 1 to 8
// RQ2 - CF control: read-back channels 9 to 16
// RQ3 - Reply shifts input levels plus fault bits
// RQ4 - Upper reply carries channels 9 to 16
// RQ5 - A0 control: echo test next frame
// RQ6 - AF control: echo test next frame
// RQ7 - Echo frame loops input to output
// RQ8 - 16-bit MSB-first frames, reply next frame
// RQ9 - Unknown control gives all-zero next frame
// RQ10 - Clear reported group faults at frame start
// RQ11 - Fault bit set when code not no-fault
module spi_readback_echo_decoder (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // Serial pins
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic        si_i,
   output logic             so_o,
   output logic             so_oe_o,
   // Device status
   input  wire logic [15:0] parallel_input_i,
   input  wire logic [31:0] diag_code_i,
   // Diagnosis clear strobes for each group
   output logic             diag_clr_low_o,
   output logic             diag_clr_high_o
);
   readback_pkg::pins_type   pins_s;
   logic [15:0]              par_s;
   readback_pkg::reply_type  reply_q;
   readback_pkg::reply_type  active_q;
   logic [`FRAME_BITS-1:0]   shift_q;
   logic [`FRAME_BITS-1:0]   rx_q;
   logic [4:0]               cnt_q;
   logic                     sclk_q;
   logic                     cs_n_q;

   // Each channel's fault bit from its 2-bit code
   function automatic logic [7:0] fault_bits(input logic [15:0] codes);
      logic [7:0] f;
      f = 8'h00;
      for (int i = 0; i < `GROUP_CHANNELS; i++) begin
         // RQ11 fault vs no-fault
         f[i] = (codes[2*i +: 2] != `DIAG_NO_FAULT);
      end
      return f;
   endfunction

   pin_sync #(.WIDTH(3), .IDLE(`PINS_IDLE)) u_sync (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .async_i  ({sclk_i, cs_n_i, si_i}),
      .sync_o   (pins_s)
   );

   // Parallel inputs are pins as well: synchronise before use
   pin_sync #(.WIDTH(16), .IDLE(`PAR_IDLE)) u_par_sync (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .async_i  (parallel_input_i),
      .sync_o   (par_s)
   );

   // Edge decode on synchronised pins
   wire frame_start = cs_n_q && !pins_s.cs_n;
   wire frame_end   = !cs_n_q && pins_s.cs_n;
   wire sclk_rise   = !sclk_q && pins_s.sclk && !pins_s.cs_n;
   wire sclk_fall   = sclk_q && !pins_s.sclk && !pins_s.cs_n;
   wire full_frame  = (cnt_q == 5'(`FRAME_BITS));
   wire [7:0] ctrl  = rx_q[15:8];

   // RQ1 lower read-back
   wire is_low  = ctrl == `CTRL_READ_LOW;
   // RQ2 upper read-back
   wire is_high = ctrl == `CTRL_READ_HIGH;
   // RQ5 RQ6 echo codes
   wire is_echo = (ctrl == `CTRL_ECHO_A) || (ctrl == `CTRL_ECHO_B);

   // RQ9 unknown or short frames map to zero reply
   wire readback_pkg::reply_type next_reply =
      !full_frame ? readback_pkg::REPLY_ZERO :
      is_low      ? readback_pkg::REPLY_LOW  :
      is_high     ? readback_pkg::REPLY_HIGH :
      is_echo     ? readback_pkg::REPLY_ECHO :
                    readback_pkg::REPLY_ZERO;

   // RQ3 RQ4 reply word: inputs high byte, faults low byte
   wire [15:0] low_word  = {par_s[7:0],
                            fault_bits(diag_code_i[15:0])};
   wire [15:0] high_word = {par_s[15:8],
                            fault_bits(diag_code_i[31:16])};
   wire [15:0] load_word =
      (reply_q == readback_pkg::REPLY_LOW)  ? low_word  :
      (reply_q == readback_pkg::REPLY_HIGH) ? high_word :
                                              16'h0000;

   // Pin history for edge detection
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sclk_q <= pins_s.sclk;
         cs_n_q <= pins_s.cs_n;
      end
   end

   // RQ8 receive MSB first and count bits
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rx_q  <= 16'h0000;
         cnt_q <= 5'h00;
      end else if (frame_start) begin
         cnt_q <= 5'h00;
      end else if (sclk_fall) begin
         rx_q  <= {rx_q[14:0], pins_s.si};
         cnt_q <= full_frame ? cnt_q : cnt_q + 5'h01;
      end
   end

   // RQ8 command decoded at frame end, used next frame
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         reply_q <= readback_pkg::REPLY_ZERO;
      end else if (frame_end) begin
         reply_q <= next_reply;
      end
   end

   // RQ3 load reply at frame start, shift on rising clock
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         shift_q  <= 16'h0000;
         active_q <= readback_pkg::REPLY_ZERO;
      end else if (frame_start) begin
         shift_q  <= load_word;
         active_q <= reply_q;
      end else if (sclk_rise && cnt_q != 5'h00) begin
         shift_q  <= {shift_q[14:0], 1'b0};
      end
   end

   // RQ7 echo loops input, otherwise shifter MSB
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         so_o    <= 1'b0;
         so_oe_o <= 1'b0;
      end else begin
         so_oe_o <= !pins_s.cs_n;
         so_o    <= (active_q == readback_pkg::REPLY_ECHO) ?
                    pins_s.si : shift_q[15];
      end
   end

   // RQ10 clear group just read, one-cycle pulse
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         diag_clr_low_o  <= 1'b0;
         diag_clr_high_o <= 1'b0;
      end else begin
         diag_clr_low_o  <= frame_start &&
                            reply_q == readback_pkg::REPLY_LOW;
         diag_clr_high_o <= frame_start &&
                            reply_q == readback_pkg::REPLY_HIGH;
      end
   end

   // Assertions all run on the device clock, held off in reset
   default clocking assert_cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   reply_low_a: assert property ( // RQ1
      frame_end && full_frame && is_low |=>
      reply_q == readback_pkg::REPLY_LOW)
      else $error("low read-back not set");
   reply_high_a: assert property ( // RQ2
      frame_end && full_frame && is_high |=>
      reply_q == readback_pkg::REPLY_HIGH)
      else $error("high read-back not set");
   load_low_a: assert property ( // RQ3
      frame_start && reply_q == readback_pkg::REPLY_LOW |=>
      shift_q == $past(low_word))
      else $error("low reply wrong");
   load_high_a: assert property ( // RQ4
      frame_start && reply_q == readback_pkg::REPLY_HIGH |=>
      shift_q == $past(high_word))
      else $error("high reply wrong");
   echo_set_a: assert property ( // RQ5
      frame_end && full_frame && (ctrl == `CTRL_ECHO_A) |=>
      reply_q == readback_pkg::REPLY_ECHO)
      else $error("echo A not set");
   echo_b_a: assert property ( // RQ6
      frame_end && full_frame && (ctrl == `CTRL_ECHO_B) |=>
      reply_q == readback_pkg::REPLY_ECHO)
      else $error("echo B not set");
   echo_path_a: assert property ( // RQ7
      active_q == readback_pkg::REPLY_ECHO && !frame_start |=>
      so_o == $past(pins_s.si))
      else $error("echo path broken");
   reject_zero_a: assert property ( // RQ9
      frame_end && !is_low && !is_high && !is_echo |=>
      reply_q == readback_pkg::REPLY_ZERO)
      else $error("reject failed");
   load_zero_a: assert property ( // RQ9
      frame_start && reply_q == readback_pkg::REPLY_ZERO |=>
      shift_q == 16'h0000)
      else $error("zero reply not loaded");
   clear_low_a: assert property ( // RQ10
      frame_start && reply_q == readback_pkg::REPLY_LOW |=>
      diag_clr_low_o && !diag_clr_high_o)
      else $error("low clear wrong");
   clear_high_a: assert property ( // RQ10
      frame_start && reply_q == readback_pkg::REPLY_HIGH |=>
      diag_clr_high_o && !diag_clr_low_o)
      else $error("high clear wrong");
   short_frame_a: assert property ( // RQ8
      frame_end && !full_frame |=>
      reply_q == readback_pkg::REPLY_ZERO)
      else $error("short frame accepted");
   oe_follow_a: assert property ( // RQ8
      so_oe_o == !$past(pins_s.cs_n))
      else $error("output enable not following select");

   cov_low_c:  cover property (@(posedge clk_i) diag_clr_low_o);
   cov_high_c: cover property (@(posedge clk_i) diag_clr_high_o);
   cov_echo_c: cover property (@(posedge clk_i)
      active_q == readback_pkg::REPLY_ECHO && sclk_fall);
endmodule

/* hw/readback_defines.svh */
/*
 Timing-free constants for the serial command decoder: frame length,
 control byte codes and diagnosis code meaning.
 Assumes inclusion by bare name from the design files.
*/
`ifndef READBACK_DEFINES_SVH
`define READBACK_DEFINES_SVH

`define FRAME_BITS       16
`define CTRL_READ_LOW    8'hC0
`define CTRL_READ_HIGH   8'hCF
`define CTRL_ECHO_A      8'hA0
`define CTRL_ECHO_B      8'hAF
`define DIAG_NO_FAULT    2'h3
`define GROUP_CHANNELS   8
`define PINS_IDLE        3'h2
`define PAR_IDLE         16'h0000

`endif

/* hw/readback_pkg.sv */
/*
 Types shared by the serial command decoder files.
 Assumes the defines header is compiled alongside.
*/
package readback_pkg;

   // Reply scheduled for the following frame
   typedef enum logic [1:0] {
      REPLY_ZERO = 2'b00,
      REPLY_LOW  = 2'b01,
      REPLY_HIGH = 2'b10,
      REPLY_ECHO = 2'b11
   } reply_type;

   // Synchronised serial pins
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic si;
   } pins_type;

endpackage

/* hw/pin_sync.sv */
/*
 Two-flop synchroniser for the serial pins.
 Assumes pins are asynchronous to clk_i.
*/
`timescale 1ns/10ps
module pin_sync #(
   parameter int               WIDTH = 3,
   parameter logic [WIDTH-1:0] IDLE  = '1
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   // Pins
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   // First stage only feeds the second; reset to idle levels
   // so that no false edge follows reset
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         meta_q <= IDLE;
         sync_o <= IDLE;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

/* test/spi_master_model.sv */
/*
 SPI master model: frames MSB first, SCLK idle low, SI set on rise.
 Assumes the device answers within eight clk_i cycles of an edge.
*/
`timescale 1ns/10ps
module spi_master_model (
   // Clock
   input  wire logic clk_i,
   // Serial pins
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      si_o,
   input  wire logic so_i,
   input  wire logic so_oe_i
);
   logic oe_all;
   // Idle pins
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      si_o   = 1'b0;
   end
   task automatic frame(input logic [15:0] tx, input int nbits,
                        output logic [15:0] rx);
      oe_all = 1'b1;
      rx = 16'h0000;
      @(negedge clk_i) cs_n_o = 1'b0;
      repeat (8) @(negedge clk_i);
      for (int i = 15; i > 15 - nbits; i--) begin
         sclk_o = 1'b1;
         si_o = tx[i];
         repeat (8) @(negedge clk_i);
         sclk_o = 1'b0;
         rx[i] = so_i; // Sampled on falling SCLK
         oe_all &= so_oe_i;
         repeat (8) @(negedge clk_i);
      end
      cs_n_o = 1'b1;
      si_o = ~si_o; // Released line must not hold the last bit
      repeat (8) @(negedge clk_i);
   endtask
endmodule

/* test/tb_spi_readback_echo_decoder.sv */
/*
 Self-checking bench for the serial command decoder.
 Assumes the master model drives all serial pins.
*/
`timescale 1ns/10ps
`include "readback_defines.svh"
module tb_spi_readback_echo_decoder;
   // Clock, reset and device signals
   logic                   clk_i = 1'b0;
   logic                   resetn_i = 1'b0;
   logic                   sclk, cs_n, si, so, so_oe, clr_lo, clr_hi;
   logic [15:0]            pins = 16'h0000;
   logic [31:0]            diag = 32'hFFFFFFFF;
   logic [15:0]            rx;
   logic [31:0]            seed = 32'h00017334;
   logic [7:0]             codes [8] = '{8'hC0, 8'hCF, 8'hA0, 8'hAF,
                                         8'h30, 8'h00, 8'hC0, 8'hF0};
   readback_pkg::reply_type pend = readback_pkg::REPLY_ZERO;
   int                     fails = 0, num_checks = 0, cycles = 0;
   int                     n_lo, n_hi;

   always #10 clk_i = ~clk_i;

   spi_readback_echo_decoder dut (.clk_i(clk_i), .resetn_i(resetn_i),
      .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .so_o(so),
      .so_oe_o(so_oe), .parallel_input_i(pins), .diag_code_i(diag),
      .diag_clr_low_o(clr_lo), .diag_clr_high_o(clr_hi));
   spi_master_model master (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n),
      .si_o(si), .so_i(so), .so_oe_i(so_oe));

   // Clear pulse counters and hang guard
   always @(posedge clk_i) begin
      if (clr_lo === 1'b1) n_lo++;
      if (clr_hi === 1'b1) n_hi++;
      cycles++;
      if (cycles == 30000) begin
         fails++;
         complete_run();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Group reply: levels high, fault bits low, top channel first
   function automatic logic [15:0] reply(input int hi);
      logic [15:0] r;
      for (int i = 0; i < 8; i++) begin
         r[8 + i] = pins[8 * hi + i];
         r[i] = diag[16 * hi + 2 * i +: 2] != `DIAG_NO_FAULT;
      end
      return r;
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One frame against the reply scheduled by the one before
   task automatic run(input logic [15:0] tx, input int nbits);
      logic [15:0] exp;
      exp = 16'h0000;
      if (pend == readback_pkg::REPLY_LOW) exp = reply(0);
      if (pend == readback_pkg::REPLY_HIGH) exp = reply(1);
      if (pend == readback_pkg::REPLY_ECHO) exp = tx;
      n_lo = 0;
      n_hi = 0;
      master.frame(tx, nbits, rx);
      if (nbits == 16) check(rx, exp);
      check({15'h0, master.oe_all}, 16'h0001);
      check({15'h0, so_oe}, 16'h0000);
      check(16'(n_lo), {15'h0, pend == readback_pkg::REPLY_LOW});
      check(16'(n_hi), {15'h0, pend == readback_pkg::REPLY_HIGH});
      pend = readback_pkg::REPLY_ZERO; // short or unknown
      if (nbits == 16) begin
         case (tx[15:8])
            `CTRL_READ_LOW: pend = readback_pkg::REPLY_LOW;
            `CTRL_READ_HIGH: pend = readback_pkg::REPLY_HIGH;
            `CTRL_ECHO_A, `CTRL_ECHO_B: pend = readback_pkg::REPLY_ECHO;
            default: pend = readback_pkg::REPLY_ZERO;
         endcase
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Corners first, then random commands and pin states
   initial begin
      repeat (20) @(negedge clk_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge clk_i);
      pins = 16'hA5C3;
      diag = 32'h3FCF03FC;
      run(16'hC05A, 16);
      run(16'hA000, 16);
      run(16'hA55A, 16);
      run(16'hCFFF, 9);
      run(16'hAF3C, 16);
      run(16'hCF96, 16);
      run(16'hC000, 16);
      for (int k = 0; k < 40; k++) begin
         seed = lfsr(seed);
         pins = seed[15:0];
         seed = lfsr(seed);
         diag = seed;
         seed = lfsr(seed);
         run({codes[seed[18:16]], seed[7:0]}, 16);
      end
      complete_run();
   end
endmodule
